// >>> src/sbpbr_regs.vh
// Constants for the serial-bus PHY base register bank.
// Assumes a 32-bit AHB-Lite slave at 40 MHz; one register per aligned word.
`ifndef SBPBR_REGS_VH
`define SBPBR_REGS_VH

// Byte addresses: base register index times four
`define SBPBR_ADDR_REG0 8'h00
`define SBPBR_ADDR_REG1 8'h04
`define SBPBR_ADDR_REG2 8'h08
`define SBPBR_ADDR_REG3 8'h0C
`define SBPBR_ADDR_REG4 8'h10
`define SBPBR_ADDR_REG5 8'h14
`define SBPBR_ADDR_REG6 8'h18
`define SBPBR_ADDR_REG7 8'h1C

// Field positions (bit 7 of the byte is the MSB, the first printed bit)
`define SBPBR_NODEID_LSB 2
`define SBPBR_ROOT_BIT   1
`define SBPBR_CPS_BIT    0
`define SBPBR_RHB_BIT    7
`define SBPBR_LBR_BIT    6
`define SBPBR_GAP_LSB    0
`define SBPBR_EXT_LSB    5
`define SBPBR_NPORT_LSB  0
`define SBPBR_SPEED_LSB  5
`define SBPBR_DELAY_LSB  0
`define SBPBR_JITTER_LSB 5
`define SBPBR_LINK_BIT   4
`define SBPBR_CONT_BIT   3
`define SBPBR_PWR_LSB    0
`define SBPBR_RESUME_IRQ_ENABLE_BIT   7
`define SBPBR_SBR_BIT    6
`define SBPBR_CTO_BIT    5
`define SBPBR_PEI_BIT    2

// Reset and constant values
`define SBPBR_GAP_RESET  6'h3F
`define SBPBR_EXT_CODE   3'h7
`define SBPBR_NPORT_CODE 4'h3
`define SBPBR_SPEED_CODE 3'h2
`define SBPBR_DELAY_CODE 4'h0
`define SBPBR_JITTER_CODE 3'h0

// Bus reset durations
`define SBPBR_CLK_MHZ        40
`define SBPBR_LONG_RESET_US  166
`define SBPBR_SHORT_RESET_NS 1300
`define SBPBR_LONG_CYCLES    (`SBPBR_LONG_RESET_US * `SBPBR_CLK_MHZ)
`define SBPBR_SHORT_CYCLES   ((`SBPBR_SHORT_RESET_NS * `SBPBR_CLK_MHZ + 999) / 1000)

`endif

// >>> src/sbpbr_base_regs.v
// Base configuration/status registers of a three-port cable PHY, AHB-Lite slave.
// Assumes the PHY core supplies arbitration, tree-ID, self-ID and resume events.
// Overview of operation
// - Hold 6-bit node ID, flag valid after self-ID
// - Root flag cleared on bus reset, set by tree-ID
// - Cable power bit follows sense input
// - Root holdoff requests root, survives bus reset
// - Long reset request starts 166 us reset
// - Ongoing receive/transmit finishes before reset starts
// - Long request cleared by hardware or bus reset
// - Gap count drives arbitration gap timing
// - Gap count set by write or config packet
// - Gap reloads 3Fh on reset or two resets
// - Extended register code reads 111b
// - Port count reads 3
// - Speed capability reads 010b
// - Repeater delay field reads 0
// - Repeater jitter field reads 0
// - Self-ID link bit is link-active AND power
// - Contender bit from pin at reset to self-ID
// - Power class from pins at reset to self-ID
// - Resume enable gates port event flag
// - Short reset request starts 1.3 us reset
// - Config time-out flag set by hardware, W1C
// - Reserved fields and registers read zero
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`include "sbpbr_regs.vh"

module sbpbr_base_regs #(
    parameter LONG_CYCLES = `SBPBR_LONG_CYCLES
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        selfIdDone,
    input  wire [5:0]  selfIdNodeId,
    input  wire        treeIdRoot,
    input  wire        cableSense,
    input  wire        pktBusy,
    input  wire        cfgGapValid,
    input  wire [5:0]  cfgGapValue,
    input  wire        arbCfgTimeout,
    input  wire        resumeStart,
    input  wire        linkPowerStatus,
    input  wire        contenderLinkonPin,
    input  wire [2:0]  powerClassPins,
    output reg         busResetActive,
    output reg         busResetShort,
    output wire        nodeIdValid,
    output wire [5:0]  arbGapCount,
    output wire        rootHoldoff,
    output wire        selfIdLinkBit,
    output wire        selfIdContBit,
    output wire [2:0]  selfIdPwrClass,
    output wire        portEventFlag,
    output wire        statusPush
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_WAIT  = 3'b010;
    localparam ST_RESET = 3'b100;

    // Short reset length in clocks, rounded up so the reset is never cut short
    localparam SHORT_CYCLES = `SBPBR_SHORT_CYCLES;

    reg [5:0]  nodeId_reg;
    reg        idValid_reg;
    reg        root_reg;
    reg        holdoff_reg;
    reg        longReq_reg;
    reg        shortReq_reg;
    reg [5:0]  gap_reg;
    reg        gapTouched_reg;
    reg        resetSeen_reg;
    reg        link_reg;
    reg        cont_reg;
    reg [2:0]  pwr_reg;
    reg        resume_irq_enable_reg;
    reg        cto_reg;
    reg        pei_reg;
    reg        push_reg;
    reg        strapDone_reg;
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [17:0] cnt_reg;
    reg        wrPend_reg;
    reg [2:0]  wrIdx_reg;
    reg [31:0] rdata_reg;

    wire       busResetEnd;
    wire       addrPhase;
    wire [2:0] idx;
    wire [7:0] wb;
    wire       inMap;
    wire       wrReg1;
    wire       wrReg4;
    wire       wrReg5;
    wire [7:0] img0;
    wire [7:0] img1;
    wire [7:0] img2;
    wire [7:0] img3;
    wire [7:0] img4;
    wire [7:0] img5;
    reg  [7:0] rdImage;

    assign addrPhase = hsel & hready & htrans[1];
    assign idx       = haddr[4:2];
    assign wb        = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;
    assign busResetEnd = (state_reg == ST_RESET) && (cnt_reg == 18'h00001);
    // Only the eight base words are mapped; higher addresses alias nothing
    assign inMap  = (haddr[7:5] == 3'b000);
    assign wrReg1 = wrPend_reg && (wrIdx_reg == 3'd1);
    assign wrReg4 = wrPend_reg && (wrIdx_reg == 3'd4);
    assign wrReg5 = wrPend_reg && (wrIdx_reg == 3'd5);

    // Register images, byte-wide; bit 7 is the first printed bit
    assign img0 = {nodeId_reg,
                   root_reg,
                   cableSense};
    assign img1 = {holdoff_reg,
                   longReq_reg,
                   gap_reg};
    assign img2 = {`SBPBR_EXT_CODE,
                   1'b0,
                   `SBPBR_NPORT_CODE};
    assign img3 = {`SBPBR_SPEED_CODE,
                   1'b0,
                   `SBPBR_DELAY_CODE};
    assign img4 = {`SBPBR_JITTER_CODE,
                   link_reg,
                   cont_reg,
                   pwr_reg};
    assign img5 = {resume_irq_enable_reg,
                   shortReq_reg,
                   cto_reg,
                   2'b00,
                   pei_reg,
                   2'b00};

    // Read mux; anything outside the eight base words reads as zero
    always @*
    begin
        rdImage = 8'h00;
        if (!inMap)
            rdImage = 8'h00;
        else if (idx == 3'd0)
            rdImage = img0;
        else if (idx == 3'd1)
            rdImage = img1;
        else if (idx == 3'd2)
            rdImage = img2;
        else if (idx == 3'd3)
            rdImage = img3;
        else if (idx == 3'd4)
            rdImage = img4;
        else if (idx == 3'd5)
            rdImage = img5;
    end

    // AHB-Lite: zero wait states; write lands in data phase
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            wrPend_reg <= 1'b0;
            wrIdx_reg  <= 3'd0;
            rdata_reg  <= 32'h00000000;
        end
        else
        begin
            wrPend_reg <= addrPhase & hwrite & inMap;
            if (addrPhase)
                wrIdx_reg <= idx;
            if (addrPhase && !hwrite)
                rdata_reg <= {24'h000000, rdImage};
        end
    end

    // Bus reset sequencer
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (longReq_reg || shortReq_reg)
                    state_next = pktBusy ? ST_WAIT : ST_RESET;
            ST_WAIT:
                if (!pktBusy)
                    state_next = ST_RESET;
            ST_RESET:
                if (busResetEnd)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state_reg      <= ST_IDLE;
            cnt_reg        <= 18'h00000;
            busResetActive <= 1'b0;
            busResetShort  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg != ST_RESET && state_next == ST_RESET)
            begin
                busResetActive <= 1'b1;
                // Long wins when both are pending; it is the safer reset
                busResetShort <= ~longReq_reg;
                if (longReq_reg)
                    cnt_reg <= LONG_CYCLES[17:0];
                else
                    cnt_reg <= SHORT_CYCLES[17:0];
            end
            else if (state_reg == ST_RESET)
            begin
                cnt_reg <= cnt_reg - 18'h00001;
                if (busResetEnd)
                    busResetActive <= 1'b0;
            end
        end
    end

    // Identity and topology: node ID, valid flag, root, status push
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            nodeId_reg  <= 6'h00;
            idValid_reg <= 1'b0;
            root_reg    <= 1'b0;
            push_reg    <= 1'b0;
        end
        else
        begin
            push_reg <= 1'b0;
            if (treeIdRoot)
                root_reg <= 1'b1;
            if (selfIdDone)
            begin
                nodeId_reg  <= selfIdNodeId;
                idValid_reg <= 1'b1;
                push_reg    <= 1'b1;
            end
            // Tree-ID and self-ID only follow a finished reset, so reset wins
            if (busResetEnd)
            begin
                root_reg    <= 1'b0;
                idValid_reg <= 1'b0;
            end
        end
    end

    // Gap count: register write, configuration packet or default reload
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            gap_reg        <= `SBPBR_GAP_RESET;
            gapTouched_reg <= 1'b0;
            resetSeen_reg  <= 1'b0;
        end
        else
        begin
            if (wrReg1)
            begin
                gap_reg        <= wb[`SBPBR_GAP_LSB +: 6];
                gapTouched_reg <= 1'b1;
            end
            if (cfgGapValid)
            begin
                gap_reg        <= cfgGapValue;
                gapTouched_reg <= 1'b1;
            end
            if (busResetEnd)
            begin
                // Second reset in a row without a gap update restores default
                if (resetSeen_reg && !gapTouched_reg && !cfgGapValid && !wrReg1)
                    gap_reg <= `SBPBR_GAP_RESET;
                resetSeen_reg  <= 1'b1;
                // An update landing with the reset still counts for the next one
                gapTouched_reg <= cfgGapValid | wrReg1;
            end
        end
    end

    // Software controls and strapped self-ID fields
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            holdoff_reg   <= 1'b0;
            longReq_reg   <= 1'b0;
            shortReq_reg  <= 1'b0;
            link_reg      <= 1'b1;
            cont_reg      <= 1'b0;
            pwr_reg       <= 3'h0;
            resume_irq_enable_reg      <= 1'b0;
            strapDone_reg <= 1'b0;
        end
        else
        begin
            strapDone_reg <= 1'b1;
            // Straps are caught on the first clock after release;
            // a write in that same cycle loses to the pins
            if (!strapDone_reg)
            begin
                cont_reg <= contenderLinkonPin;
                pwr_reg  <= powerClassPins;
            end
            if (wrReg1)
            begin
                holdoff_reg <= wb[`SBPBR_RHB_BIT];
                longReq_reg <= wb[`SBPBR_LBR_BIT];
            end
            else if (wrReg4)
            begin
                link_reg <= wb[`SBPBR_LINK_BIT];
                if (strapDone_reg)
                begin
                    cont_reg <= wb[`SBPBR_CONT_BIT];
                    pwr_reg  <= wb[`SBPBR_PWR_LSB +: 3];
                end
            end
            else if (wrReg5)
            begin
                resume_irq_enable_reg     <= wb[`SBPBR_RESUME_IRQ_ENABLE_BIT];
                shortReq_reg <= wb[`SBPBR_SBR_BIT];
            end
            if (busResetEnd)
            begin
                longReq_reg  <= 1'b0;
                shortReq_reg <= 1'b0;
            end
        end
    end

    // Event flags: a hardware set wins over a software clear in one cycle
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            cto_reg <= 1'b0;
            pei_reg <= 1'b0;
        end
        else
        begin
            if (wrReg5 && wb[`SBPBR_CTO_BIT])
                cto_reg <= 1'b0;
            if (wrReg5 && wb[`SBPBR_PEI_BIT])
                pei_reg <= 1'b0;
            if (arbCfgTimeout)
                cto_reg <= 1'b1;
            if (resumeStart && resume_irq_enable_reg)
                pei_reg <= 1'b1;
        end
    end

    assign nodeIdValid    = idValid_reg;
    assign statusPush     = push_reg;
    assign arbGapCount    = gap_reg;
    assign rootHoldoff    = holdoff_reg;
    assign selfIdLinkBit  = link_reg & linkPowerStatus;
    assign selfIdContBit  = cont_reg;
    assign selfIdPwrClass = pwr_reg;
    assign portEventFlag  = pei_reg;

endmodule // sbpbr_base_regs

// >>> bench/sbpbr_props.sv
// Checker for the base register bank, watching the top module's ports only.
// Assumes a zero-wait slave, so the address phase alone qualifies a read.
module sbpbr_props (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        cableSense,
    input wire logic        pktBusy,
    input wire logic        cfgGapValid,
    input wire logic [5:0]  cfgGapValue,
    input wire logic        selfIdDone,
    input wire logic [2:0]  powerClassPins,
    input wire logic        busResetActive,
    input wire logic        nodeIdValid,
    input wire logic [5:0]  arbGapCount,
    input wire logic [2:0]  selfIdPwrClass
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire rdA = hsel && htrans[1] && !hwrite;
    property p_cps; rdA && haddr == 8'h00 |=> hrdata[0] == $past(cableSense); endproperty
    a_cps: assert property (p_cps) else $error("cable power bit wrong");
    property p_ext; rdA && haddr == 8'h08 |=> hrdata == 32'h000000E3; endproperty
    a_ext: assert property (p_ext) else $error("register 2 wrong");
    property p_spd; rdA && haddr == 8'h0C |=> hrdata == 32'h00000040; endproperty
    a_spd: assert property (p_spd) else $error("register 3 wrong");
    property p_rsv; rdA && haddr[7:3] == 5'h03 |=> hrdata == 32'h00000000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read not zero");
    property p_busy; $rose(busResetActive) |-> !$past(pktBusy); endproperty
    a_busy: assert property (p_busy) else $error("reset began during packet");
    property p_len; $rose(busResetActive) |=> busResetActive [*8]; endproperty
    a_len: assert property (p_len) else $error("bus reset too short");
    property p_gaprst; disable iff (1'b0) !nrst |=> arbGapCount == 6'h3F; endproperty
    a_gaprst: assert property (p_gaprst) else $error("gap not reloaded");
    property p_cfg; cfgGapValid && !busResetActive |=> arbGapCount == $past(cfgGapValue); endproperty
    a_cfg: assert property (p_cfg) else $error("gap packet ignored");
    property p_nid; selfIdDone |=> nodeIdValid; endproperty
    a_nid: assert property (p_nid) else $error("node id not valid");
    property p_pwr; $rose(nrst) |=> selfIdPwrClass == $past(powerClassPins); endproperty
    a_pwr: assert property (p_pwr) else $error("power class not strapped");
endmodule // sbpbr_props
bind sbpbr_base_regs sbpbr_props i_sbpbr_props (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .cableSense(cableSense), .pktBusy(pktBusy),
    .cfgGapValid(cfgGapValid), .cfgGapValue(cfgGapValue), .selfIdDone(selfIdDone),
    .powerClassPins(powerClassPins), .busResetActive(busResetActive), .nodeIdValid(nodeIdValid),
    .arbGapCount(arbGapCount), .selfIdPwrClass(selfIdPwrClass));

// >>> bench/sbpbr_link_model.sv
// Link-layer side: AHB-Lite master doing single word transfers.
// Assumes the one slave's hreadyout comes back as hready.
module sbpbr_link_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [7:0]       haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             rdDone,
    output logic [31:0]      rdData
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata, rdDone, rdData} = '0;
    always @(posedge clk) if (rdDone) rdDone <= 1'b0;
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        // Reads drive inverted data so a stale bus never looks like a write
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wr ? d : ~d;
        do @(posedge clk); while (hready !== 1'b1);
        if (!wr)
        begin
            rdData <= hrdata;
            rdDone <= 1'b1;
        end
    endtask
endmodule // sbpbr_link_model

// >>> bench/tb_top.sv
// Self-checking bench for the base register bank.
// Assumes a short long-reset count (20 cycles) to keep the run brief.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, nrst = 0, selfIdDone = 0, treeIdRoot = 0, cableSense = 1, pktBusy = 0;
    logic cfgGapValid = 0, arbCfgTimeout = 0, resumeStart = 0, linkPowerStatus = 1, contenderLinkonPin = 1;
    logic [5:0] selfIdNodeId = 0, cfgGapValue = 0, g, n;
    logic [2:0] powerClassPins = 3'h5, hsize;
    logic [1:0] htrans;
    logic [7:0] haddr;
    logic [31:0] hwdata, hrdata, rdData;
    logic hsel, hwrite, hreadyout, rdDone, busResetActive;
    logic busResetShort, nodeIdValid, rootHoldoff, selfIdLinkBit, selfIdContBit, portEventFlag, statusPush;
    logic [5:0] arbGapCount;
    logic [2:0] selfIdPwrClass;
    int pushCount = 0;
    logic [39:0] expQ[$], e;
    logic [7:0] rst0 [9] = '{8'h01, 8'h3F, 8'hE3, 8'h40, 8'h1D, 8'h00, 8'h00, 8'h00, 8'h00};
    int failures = 0, cmp_count = 0, k;
    always #12.5 clk = ~clk;
    sbpbr_base_regs #(.LONG_CYCLES(20)) i_sbpbr_base_regs (.clk(clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .selfIdDone(selfIdDone), .selfIdNodeId(selfIdNodeId),
        .treeIdRoot(treeIdRoot), .cableSense(cableSense), .pktBusy(pktBusy), .cfgGapValid(cfgGapValid),
        .cfgGapValue(cfgGapValue), .arbCfgTimeout(arbCfgTimeout), .resumeStart(resumeStart),
        .linkPowerStatus(linkPowerStatus), .contenderLinkonPin(contenderLinkonPin),
        .powerClassPins(powerClassPins), .busResetActive(busResetActive), .busResetShort(busResetShort),
        .nodeIdValid(nodeIdValid), .arbGapCount(arbGapCount), .rootHoldoff(rootHoldoff),
        .selfIdLinkBit(selfIdLinkBit), .selfIdContBit(selfIdContBit), .selfIdPwrClass(selfIdPwrClass),
        .portEventFlag(portEventFlag), .statusPush(statusPush));
    always @(posedge clk) if (statusPush === 1'b1) pushCount++;
    sbpbr_link_model i_sbpbr_link_model (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rdDone(rdDone),
        .rdData(rdData));
    task automatic chk(input logic [7:0] a, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD reg %h exp %h got %h", a, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        expQ.push_back({a, 24'h0, x});
        i_sbpbr_link_model.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sbpbr_link_model.xfer(1'b1, a, {24'h0, d});
    endtask
    // Bounded wait for one whole bus reset, start then end
    task automatic waitReset;
        for (k = 0; k < 300 && busResetActive !== 1'b1; k++) @(posedge clk);
        for (k = 0; k < 300 && busResetActive !== 1'b0; k++) @(posedge clk);
        if (k == 300) failures++;
    endtask
    task automatic end_sim;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
    if (rdDone === 1'b1)
    begin
        e = expQ.pop_front();
        chk(e[39:32], rdData, e[31:0]);
    end
    initial
    begin
        #(25 * 20000);
        failures++;
        end_sim;
    end
    initial
    begin
        k = $urandom(32);
        g = $urandom;
        n = $urandom;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) rd(8'(i * 4), rst0[i]);
        chk(8'hA1, {27'h0, selfIdLinkBit, selfIdContBit, selfIdPwrClass}, 32'h1D);
        linkPowerStatus <= 1'b0;
        @(posedge clk);
        chk(8'hA2, {31'h0, selfIdLinkBit}, 32'h0);
        linkPowerStatus <= 1'b1;
        wr(8'h08, 8'hFF);
        rd(8'h08, 8'hE3);
        wr(8'h04, {2'b10, g});
        rd(8'h04, {2'b10, g});
        @(posedge clk);
        chk(8'hA3, {25'h0, rootHoldoff, arbGapCount}, {25'h0, 1'b1, g});
        wr(8'h14, 8'h80);
        @(posedge clk) {resumeStart, arbCfgTimeout} <= 2'b11;
        @(posedge clk) {resumeStart, arbCfgTimeout} <= 2'b00;
        rd(8'h14, 8'hA4);
        chk(8'hA8, {31'h0, portEventFlag}, 32'h1);
        wr(8'h14, 8'hA4);
        rd(8'h14, 8'h80);
        chk(8'hA8, {31'h0, portEventFlag}, 32'h0);
        @(posedge clk) {selfIdNodeId, selfIdDone, treeIdRoot, cfgGapValue} <= {n, 2'b11, ~g};
        @(posedge clk) {selfIdDone, treeIdRoot, cfgGapValid} <= 3'b001;
        @(posedge clk) cfgGapValid <= 1'b0;
        rd(8'h00, {n, 2'b11});
        rd(8'h04, {2'b10, ~g});
        chk(8'hA4, {25'h0, nodeIdValid, arbGapCount}, {25'h0, 1'b1, ~g});
        // Packet in flight holds off the long reset
        pktBusy <= 1'b1;
        wr(8'h04, {2'b11, ~g});
        repeat (10) @(posedge clk);
        chk(8'hA9, {31'h0, busResetActive}, 32'h0);
        pktBusy <= 1'b0;
        waitReset;
        chk(8'hA6, {30'h0, nodeIdValid, busResetShort}, 32'h0);
        cableSense <= 1'b0;
        rd(8'h04, {2'b10, ~g});
        rd(8'h00, {n, 2'b00});
        rd(8'h10, 8'h1D);
        wr(8'h14, 8'h40);
        waitReset;
        chk(8'hA7, {31'h0, busResetShort}, 32'h1);
        rd(8'h14, 8'h00);
        rd(8'h04, 8'hBF);
        repeat (4) @(posedge clk);
        chk(8'hA5, pushCount, 32'd1);
        chk(8'hAA, {26'h0, arbGapCount}, 32'h3F);
        end_sim;
    end
endmodule // tb_top
